/* File: adcsb_pkg.sv */
// Package for the converter housekeeping block: pin codes, counts and divider figures.
// Assumes a single 40 MHz clock and synchronous active-high reset in every user.
package adcsb_pkg;
   localparam int unsigned NUM_CH = 8;
   localparam int unsigned STARTUP_LOG2 = 18;
   localparam int unsigned STARTUP_CYCLES = 1 << STARTUP_LOG2;
   localparam int unsigned SUPPRESS_CONV = 129;
   localparam logic [1:0] TEST_NORMAL = 2'h0;
   localparam logic [1:0] TEST_PINS = 2'h3;
   localparam logic [2:0] FMT_SPI_A = 3'h0;
   localparam logic [2:0] FMT_SPI_B = 3'h1;
   localparam logic [2:0] FMT_FRAME_A = 3'h3;
   localparam logic [2:0] FMT_FRAME_B = 3'h4;
   localparam logic [2:0] FMT_BITSTREAM = 3'h6;
   localparam logic [1:0] SPEED_0 = 2'h0;
   localparam logic [1:0] SPEED_1 = 2'h1;
   localparam logic [1:0] SPEED_2 = 2'h2;
   localparam logic [1:0] SPEED_3 = 2'h3;
   localparam logic [5:0] DIV_4 = 6'h04;
   localparam logic [5:0] DIV_8 = 6'h08;
   localparam logic [5:0] DIV_40 = 6'h28;
   localparam int unsigned FIFO_DEPTH = 32;
   localparam int unsigned FIFO_WIDTH = 8;
   localparam logic [7:0] DENSITY_POS = 8'hCC;
   localparam logic [7:0] DENSITY_NEG = 8'h33;
   typedef enum logic [1:0] {
      ADCSB_ST_STARTUP = 2'b00,
      ADCSB_ST_SUPPRESS = 2'b01,
      ADCSB_ST_RUN = 2'b10
   } adcsb_state_t;
endpackage

/* File: adcsb_fifo.sv */
// Synchronous FIFO with parameter width and depth, valid/ready on both sides.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module adcsb_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 32
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   // Pointer and fill-count next values; full and empty follow the count
   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage has no reset; emptiness guards any stale word
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rd_q];
endmodule
`default_nettype wire

/* File: adcsb_moddiv.sv */
// Modulator clock divider: one-cycle tick and a square clock level.
// Assumes the division ratio changes only while the divider is held idle.
`timescale 1ns/1ps
`default_nettype none
module adcsb_moddiv (
   input wire logic clk,
   input wire logic srst,
   input wire logic run,
   input wire logic [5:0] ratio,
   output logic tick,
   output logic level
);
   logic [5:0] cnt_q, cnt_d;

   // Count 0..ratio-1; the level is high for the first half of each period
   always_comb begin
      cnt_d = '0;
      if (run && (cnt_q != ratio - 6'h01)) begin
         cnt_d = cnt_q + 6'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign tick = run && (cnt_q == ratio - 6'h01);
   assign level = run && (cnt_q < {1'b0, ratio[5:1]});
endmodule
`default_nettype wire

/* File: adcsb_top.sv */
// Housekeeping logic of an eight-channel converter: start-up sequencing,
// modulator bitstream output and pin continuity test.
// Assumes all pin inputs are synchronous to clk and srst is the global power-on reset.
`timescale 1ns/1ps
`default_nettype none
// Function
// [RULE_01] Supply monitor resets merge into one global reset holding all logic.
// [RULE_02] After reset release, count 2^18 master clocks before converting.
// [RULE_03] Then withhold the first 129 conversion results.
// [RULE_04] SPI style: result ready output stays high during suppression.
// [RULE_05] Frame style: data outputs drive zeros during suppression.
// [RULE_06] Controller should pulse resync once when valid data first appear.
// [RULE_07] Bitstream mode: filter off, each channel bit on its own output.
// [RULE_08] Bitstream mode: shift clock pin outputs modulator clock; readout disabled.
// [RULE_09] Bitstream mode: ready/frame pin is an output without function.
// [RULE_10] Modulator clock divides master clock by 4, 8 or 40 per speed code.
// [RULE_11] Bitstream ones density about 80% at full positive, 20% full negative.
// [RULE_12] Test pins 11 select continuity test; 00 select normal operation.
// [RULE_13] Test codes 01 and 10 must never be applied.
// [RULE_14] Test mode suspends digital pin functions; analog side unaffected.
// [RULE_15] Test mode: channel sleep input n drives data output n.
// [RULE_16] Test mode: speed and style bits drive chain, resync, divider, ready, clock.
// [RULE_17] A dedicated style code selects bitstream output.
// [RULE_18] While start-up counter runs, no data; ready and data stay idle.
// [RULE_19] Style 000/001 is SPI readout; 011/100 is frame readout.
module adcsb_top
   import adcsb_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [1:0] test_sel,
   input wire logic [2:0] style_sel,
   input wire logic [1:0] speed_sel,
   input wire logic master_divider_select_in,
   input wire logic [NUM_CH-1:0] channel_sleep_in,
   input wire logic chain_in,
   input wire logic resync_in,
   input wire logic shift_clk_in,
   input wire logic frame_strobe_in,
   input wire logic signed [NUM_CH-1:0] [7:0] mod_level_in,
   input wire logic conv_done_in,
   input wire logic [NUM_CH-1:0] conv_bit_in,
   output logic [NUM_CH-1:0] data_out,
   output logic result_ready_out,
   output logic ready_oe,
   output logic shift_clk_out,
   output logic shift_clk_oe,
   output logic chain_out,
   output logic chain_oe,
   output logic resync_out,
   output logic resync_oe,
   output logic master_divider_select_out,
   output logic master_divider_select_oe,
   output logic filter_enable,
   output logic converting
);
   adcsb_state_t st_q, st_d;
   logic [STARTUP_LOG2-1:0] cyc_q, cyc_d;
   logic [7:0] sup_q, sup_d;
   logic test_mode, bitstream, spi_style, frame_style;
   logic [5:0] ratio;
   logic mod_tick, mod_level;
   logic [NUM_CH-1:0] [7:0] acc_q, acc_d;
   logic [NUM_CH-1:0] bits_d;
   logic [NUM_CH-1:0] fifo_out;
   logic fifo_valid, fifo_in_ready;
   logic [NUM_CH-1:0] data_d;
   logic ready_d, ready_oe_d, sclk_d, sclk_oe_d;
   logic chain_d, chain_oe_d, resync_d, resync_oe_d, div_d, div_oe_d;

   // Mode decode; codes 01/10 on the test pins fall back to normal [RULE_12] [RULE_13]
   always_comb begin
      test_mode = (test_sel == TEST_PINS);
      bitstream = !test_mode && (style_sel == FMT_BITSTREAM); // [RULE_17]
      spi_style = (style_sel == FMT_SPI_A) || (style_sel == FMT_SPI_B); // [RULE_19]
      frame_style = (style_sel == FMT_FRAME_A) || (style_sel == FMT_FRAME_B); // [RULE_19]
   end

   // Divide ratio per speed code and divider select [RULE_10]
   always_comb begin
      unique case (speed_sel)
         SPEED_0: ratio = DIV_4;
         SPEED_1: ratio = DIV_4;
         SPEED_2: ratio = master_divider_select_in ? DIV_8 : DIV_4;
         SPEED_3: ratio = master_divider_select_in ? DIV_40 : DIV_8;
      endcase
   end

   // Start-up sequencer: srst is the merged supply reset [RULE_01]
   always_comb begin
      st_d = st_q;
      cyc_d = cyc_q;
      sup_d = sup_q;
      unique case (st_q)
         ADCSB_ST_STARTUP: begin
            cyc_d = cyc_q + 1'b1; // [RULE_02]
            if (cyc_q == STARTUP_LOG2'(STARTUP_CYCLES - 1)) begin
               st_d = ADCSB_ST_SUPPRESS;
            end
         end
         ADCSB_ST_SUPPRESS: begin
            if (conv_done_in) begin
               sup_d = sup_q + 8'h01; // [RULE_03]
               if (sup_q == 8'(SUPPRESS_CONV - 1)) begin
                  st_d = ADCSB_ST_RUN;
               end
            end
         end
         ADCSB_ST_RUN: st_d = ADCSB_ST_RUN;
         default: st_d = ADCSB_ST_STARTUP;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= ADCSB_ST_STARTUP;
         cyc_q <= '0;
         sup_q <= '0;
      end else begin
         st_q <= st_d;
         cyc_q <= cyc_d;
         sup_q <= sup_d;
      end
   end

   adcsb_moddiv u_div (
      .clk(clk),
      .srst(srst),
      .run(bitstream && (st_q != ADCSB_ST_STARTUP)),
      .ratio(ratio),
      .tick(mod_tick),
      .level(mod_level)
   );

   // First-order modulator per channel: overflow of the accumulator is the bit.
   // Level offset maps full scale onto roughly 80%/20% ones density [RULE_11]
   always_comb begin
      acc_d = acc_q;
      bits_d = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         logic [8:0] sum;
         logic [7:0] dens;
         sum = '0;
         dens = '0;
         dens = 8'(9'sd128 + 9'(($signed(mod_level_in[i]) * 3) / 5));
         sum = {1'b0, acc_q[i]} + {1'b0, dens};
         bits_d[i] = sum[8];
         if (mod_tick) begin
            acc_d[i] = sum[7:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         acc_q <= '0;
      end else begin
         acc_q <= acc_d;
      end
   end

   // Bit vectors buffered toward the pins; pins stall draining between ticks
   adcsb_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .srst(srst),
      .in_data(bits_d),
      .in_valid(mod_tick),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out),
      .out_valid(fifo_valid),
      .out_ready(mod_tick)
   );

   // Push and pop share the tick, so the buffer must never be found full
   chk_fifo_room: assert property (@(posedge clk) disable iff (srst)
      mod_tick |-> fifo_in_ready)
      else $error("bit buffer full at tick"); // [RULE_07]

   // Pin multiplexing for normal, bitstream and test modes
   always_comb begin
      data_d = '0;
      ready_d = 1'b1;
      ready_oe_d = spi_style;
      sclk_d = 1'b0;
      sclk_oe_d = 1'b0;
      chain_d = 1'b0;
      chain_oe_d = 1'b0;
      resync_d = 1'b0;
      resync_oe_d = 1'b0;
      div_d = 1'b0;
      div_oe_d = 1'b0;
      if (test_mode) begin
         data_d = channel_sleep_in; // [RULE_15] [RULE_14]
         chain_d = speed_sel[0]; // [RULE_16]
         chain_oe_d = 1'b1;
         resync_d = speed_sel[1]; // [RULE_16]
         resync_oe_d = 1'b1;
         div_d = style_sel[0]; // [RULE_16]
         div_oe_d = 1'b1;
         ready_d = style_sel[1]; // [RULE_16]
         ready_oe_d = 1'b1;
         sclk_d = style_sel[2]; // [RULE_16]
         sclk_oe_d = 1'b1;
      end else if (bitstream) begin
         ready_d = 1'b0; // [RULE_09]
         ready_oe_d = 1'b1;
         sclk_d = mod_level; // [RULE_08]
         sclk_oe_d = 1'b1;
         if (fifo_valid) begin
            data_d = fifo_out; // [RULE_07]
         end
      end else if (st_q == ADCSB_ST_RUN) begin
         data_d = conv_bit_in & ~channel_sleep_in;
         ready_d = !conv_done_in;
      end else begin
         data_d = '0; // [RULE_05] [RULE_18]
         ready_d = 1'b1; // [RULE_04] [RULE_18]
      end
   end

   // Outputs all registered
   always_ff @(posedge clk) begin
      if (srst) begin
         data_out <= '0;
         result_ready_out <= 1'b1;
         ready_oe <= 1'b0;
         shift_clk_out <= 1'b0;
         shift_clk_oe <= 1'b0;
         chain_out <= 1'b0;
         chain_oe <= 1'b0;
         resync_out <= 1'b0;
         resync_oe <= 1'b0;
         master_divider_select_out <= 1'b0;
         master_divider_select_oe <= 1'b0;
         filter_enable <= 1'b0;
         converting <= 1'b0;
      end else begin
         data_out <= data_d;
         result_ready_out <= ready_d;
         ready_oe <= ready_oe_d;
         shift_clk_out <= sclk_d;
         shift_clk_oe <= sclk_oe_d;
         chain_out <= chain_d;
         chain_oe <= chain_oe_d;
         resync_out <= resync_d;
         resync_oe <= resync_oe_d;
         master_divider_select_out <= div_d;
         master_divider_select_oe <= div_oe_d;
         filter_enable <= !bitstream && !test_mode && (st_q != ADCSB_ST_STARTUP); // [RULE_07]
         converting <= (st_q != ADCSB_ST_STARTUP);
      end
   end

   // No data leaves before the start-up count completes, except the test-mode loopback
   chk_startup_idle: assert property (@(posedge clk) disable iff (srst)
      (st_q == ADCSB_ST_STARTUP && !test_mode && !bitstream) |=> (data_out == '0))
      else $error("data left during start-up"); // [RULE_18]
   chk_spi_ready_high: assert property (@(posedge clk) disable iff (srst)
      (st_q == ADCSB_ST_SUPPRESS && !test_mode && !bitstream) |=> result_ready_out)
      else $error("ready low during suppression"); // [RULE_04]
   chk_frame_zero: assert property (@(posedge clk) disable iff (srst)
      (st_q != ADCSB_ST_RUN && frame_style && !test_mode) |=> (data_out == '0))
      else $error("frame data nonzero while suppressed"); // [RULE_05]
   chk_startup_length: assert property (@(posedge clk) disable iff (srst)
      (st_q == ADCSB_ST_STARTUP && st_d == ADCSB_ST_SUPPRESS) |-> (&cyc_q))
      else $error("start-up count wrong"); // [RULE_02]
   chk_suppress_count: assert property (@(posedge clk) disable iff (srst)
      (st_q == ADCSB_ST_SUPPRESS && st_d == ADCSB_ST_RUN) |-> (sup_q == 8'h80 && conv_done_in))
      else $error("suppression count wrong"); // [RULE_03]
   chk_test_loop: assert property (@(posedge clk) disable iff (srst)
      test_mode |=> (data_out == $past(channel_sleep_in)) && chain_oe && shift_clk_oe)
      else $error("test loopback wrong"); // [RULE_15]
   chk_test_pairs: assert property (@(posedge clk) disable iff (srst)
      test_mode |=> (chain_out == $past(speed_sel[0])) && (shift_clk_out == $past(style_sel[2])))
      else $error("test pin pair wrong"); // [RULE_16]
   chk_bits_sclk_out: assert property (@(posedge clk) disable iff (srst)
      bitstream |=> shift_clk_oe && ready_oe && !filter_enable)
      else $error("bitstream pin roles wrong"); // [RULE_08]
   chk_div_ratio: assert property (@(posedge clk) disable iff (srst)
      (bitstream && speed_sel == SPEED_3 && master_divider_select_in && mod_tick)
         |=> !mod_tick [*8])
      else $error("modulator tick too early"); // [RULE_10]
endmodule
`default_nettype wire

/* File: adcsb_host_model.sv */
// Model of the external filter and controller facing the converter block.
// Assumes the single 40 MHz clock and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module adcsb_host_model (
   input wire logic clk,
   input wire logic srst,
   input wire logic en,
   input wire logic clr,
   input wire logic shift_clk_out,
   input wire logic [7:0] data_out,
   output logic conv_done_in,
   output logic [7:0] conv_bit_in,
   output logic resync_in,
   output int period,
   output int ones,
   output int ticks,
   output int sent
);
   logic sclk_q;
   logic rise;
   int gap;
   int since;
   assign rise = shift_clk_out && !sclk_q;
   // Conversion pulses every 8 cycles; modulator clock period and density measured
   always_ff @(posedge clk) begin
      sclk_q <= shift_clk_out;
      if (srst) begin
         gap <= 0;
         sent <= 0;
         conv_done_in <= 1'b0;
         resync_in <= 1'b0;
         conv_bit_in <= 8'h01;
         since <= 0;
         period <= 0;
      end else begin
         gap <= (gap == 7) ? 0 : gap + 1;
         conv_done_in <= en && gap == 7;
         if (en && gap == 7) sent <= sent + 1;
         resync_in <= en && gap == 7 && sent == 129; // Single pulse once data settle
         conv_bit_in <= {conv_bit_in[6:0], ^conv_bit_in[7:5]};
         since <= rise ? 1 : since + 1;
         if (rise) period <= since; // Edges between rising modulator clock edges
      end
      // One bit per modulator period, taken at its rising edge
      if (srst || clr) begin
         ones <= 0;
         ticks <= 0;
      end else if (rise) begin
         ones <= ones + int'(data_out[0]);
         ticks <= ticks + 1;
      end
   end
endmodule
`default_nettype wire

/* File: adc_startup_bitstream_pintest_tb.sv */
// Self-checking bench for the converter housekeeping block.
// Assumes the host model file and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, g) begin checks++; if ((e) !== (g)) begin failures++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module adc_startup_bitstream_pintest_tb;
   import adcsb_pkg::*;
   typedef struct {int due; logic [19:0] exp; logic [19:0] msk;} adcsb_note_t;
   logic clk, srst, mdiv_in, en, clr;
   logic [1:0] test_sel, speed_sel;
   logic [2:0] style_sel;
   logic [7:0] sleep;
   logic signed [NUM_CH-1:0] [7:0] level;
   logic done, rsync;
   logic [7:0] cbit, data_out;
   logic rdy, rdy_oe, sck, sck_oe, chn, chn_oe, rsy, rsy_oe, mdv, mdv_oe, filt, conv;
   wire logic [19:0] pins = {data_out, rdy, rdy_oe, sck, sck_oe, chn, chn_oe,
                             rsy, rsy_oe, mdv, mdv_oe, filt, conv};
   int period, ones, ticks, sent, cyc = 0, n, checks = 0, failures = 0;
   int div_tab[6] = '{4, 4, 8, 4, 40, 8};
   adcsb_note_t q[$];
   adcsb_note_t nt;
   adcsb_top i_dut (.clk(clk), .srst(srst), .test_sel(test_sel), .style_sel(style_sel),
      .speed_sel(speed_sel), .master_divider_select_in(mdiv_in), .channel_sleep_in(sleep),
      .chain_in(1'b0), .resync_in(rsync), .shift_clk_in(1'b0), .frame_strobe_in(1'b0),
      .mod_level_in(level), .conv_done_in(done), .conv_bit_in(cbit), .data_out(data_out),
      .result_ready_out(rdy), .ready_oe(rdy_oe), .shift_clk_out(sck), .shift_clk_oe(sck_oe),
      .chain_out(chn), .chain_oe(chn_oe), .resync_out(rsy), .resync_oe(rsy_oe),
      .master_divider_select_out(mdv), .master_divider_select_oe(mdv_oe),
      .filter_enable(filt), .converting(conv));
   adcsb_host_model i_host (.clk(clk), .srst(srst), .en(en), .clr(clr), .shift_clk_out(sck),
      .data_out(data_out), .conv_done_in(done), .conv_bit_in(cbit), .resync_in(rsync),
      .period(period), .ones(ones), .ticks(ticks), .sent(sent));
   // Clock and cycle stamp for the expectation queue
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   // Expected pin values are due one registered cycle after the inputs change
   task automatic note(input logic [19:0] e, input logic [19:0] m);
      q.push_back('{cyc + 1, e, m});
   endtask
   // Monitor takes every due note, oldest first, and compares the masked pins
   always @(negedge clk) begin
      while (q.size() > 0 && q[0].due <= cyc) begin
         nt = q.pop_front();
         `CHECK("pins", nt.exp & nt.msk, pins & nt.msk)
      end
   end
   task automatic print_verdict();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Watchdog sized for the fixed start-up count plus the scenarios
   initial begin
      #(25.0 * 400000);
      failures++;
      print_verdict();
   end
   // Measure modulator density over 200 ticks at the given input level
   task automatic density(input logic [7:0] lv, input int lo, input int hi);
      level = {NUM_CH{lv}};
      repeat (300) @(negedge clk);
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      n = 0;
      while (ticks < 200 && n < 5000) begin
         @(negedge clk);
         n++;
      end
      `CHECK("density", 1'b1, ones >= lo && ones <= hi)
   endtask
   initial begin
      srst = 1'b1;
      test_sel = TEST_NORMAL; // Only legal test codes are applied
      style_sel = FMT_SPI_A;
      speed_sel = SPEED_0;
      mdiv_in = 1'b1;
      sleep = 8'h00;
      level = '0;
      en = 1'b0;
      clr = 1'b0;
      void'($urandom(41165));
      repeat (10) @(negedge clk);
      note(20'h0_0800, 20'hF_FD57);
      @(negedge clk);
      srst = 1'b0;
      n = 0;
      // Count edges until conversion starts; outputs idle meanwhile
      while (conv !== 1'b1 && n < 300000) begin
         if (n == 1000) note(20'h0_0800, 20'hF_F801);
         @(negedge clk);
         n++;
      end
      `CHECK("startup", STARTUP_CYCLES + 1, n)
      // Suppression through all four readout codes
      en = 1'b1;
      n = 0;
      while (sent < 128 && n < 3000) begin
         style_sel = (sent < 32) ? FMT_SPI_A : (sent < 64) ? FMT_SPI_B :
                     (sent < 96) ? FMT_FRAME_A : FMT_FRAME_B;
         if (sent < 64) note(20'h0_0800, 20'hF_F800);
         else note(20'h0_0000, 20'hF_F000);
         @(negedge clk);
         n++;
      end
      while (sent < 131 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      note(20'h0_0003, 20'h0_0003);
      @(negedge clk);
      // Settled: the host's data bits now reach the pins
      note({cbit & ~sleep, 12'h003}, 20'hF_F003);
      @(negedge clk);
      en = 1'b0;
      // Pin continuity test with random input patterns
      test_sel = TEST_PINS;
      repeat (20) begin
         sleep = 8'($urandom);
         speed_sel = 2'($urandom);
         style_sel = 3'($urandom);
         note({sleep, style_sel[1], 1'b1, style_sel[2], 1'b1, speed_sel[0], 1'b1,
               speed_sel[1], 1'b1, style_sel[0], 1'b1, 2'b00}, 20'hF_FFFC);
         @(negedge clk);
      end
      test_sel = TEST_NORMAL;
      style_sel = FMT_SPI_A;
      note(20'h0_0000, 20'h0_0054);
      @(negedge clk);
      // Modulator clock ratio for every speed code, with both divider settings at speeds 2 and 3
      for (int k = 0; k < 6; k++) begin
         style_sel = FMT_SPI_A;
         speed_sel = (k < 2) ? 2'(k) : (k < 4) ? SPEED_2 : SPEED_3;
         mdiv_in = (k < 2) || (k == 2) || (k == 4);
         @(negedge clk);
         style_sel = FMT_BITSTREAM;
         repeat (300) @(negedge clk);
         `CHECK("mod_period", div_tab[k], period)
         note(20'h0_0500, 20'h0_0502);
         @(negedge clk);
      end
      style_sel = FMT_SPI_A;
      speed_sel = SPEED_0;
      mdiv_in = 1'b1;
      @(negedge clk);
      style_sel = FMT_BITSTREAM;
      density(8'h7F, 140, 180);
      density(8'h80, 20, 60);
      print_verdict();
   end
endmodule
`default_nettype wire
